// [inc/spe_pkg.sv]
// spe_pkg: constants, states and carrier types for the serial programming entry block
// assumes a single 40 MHz core clock; no other package is needed
package spe_pkg;
   // ==========================================================
   // key and timing
   localparam int SPE_KEY_BITS = 32;
   // arbitrary key value, not taken from any part
   localparam logic [31:0] SPE_KEY_PATTERN = 32'h5A3C_96E1;
   localparam int SPE_CLK_PERIOD_PS = 25000;
   localparam int SPE_SYNC_STAGES = 2;
   localparam logic [5:0] SPE_CNT_ZERO = 6'h00;
   localparam logic [5:0] SPE_CNT_ONE = 6'h01;

   // ==========================================================
   // entry states, gray coded along idle -> key -> session
   typedef enum logic [1:0]
   {
      SPE_IDLE = 2'b00,
      SPE_KEY = 2'b01,
      SPE_LV_SESSION = 2'b11,
      SPE_HV_SESSION = 2'b10
   } spe_state_t;

   // ==========================================================
   // synchronised programming pins
   typedef struct packed
   {
      logic clk;
      logic dat;
      logic clear_low;
      logic hv;
   } spe_pins_t;

   // session status
   typedef struct packed
   {
      logic active;
      logic lv;
      logic hv;
   } spe_mode_t;
endpackage

// [design/spe_sync.sv]
// spe_sync: two-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous levels; first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module spe_sync #(
   parameter int WIDTH = 4
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [WIDTH-1:0] D,
   output logic [WIDTH-1:0] Q
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   always_comb
   begin
      next_meta = D;
      next_q = meta;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         meta <= '0;
         Q <= '0;
      end
      else
      begin
         meta <= next_meta;
         Q <= next_q;
      end
   end
endmodule
`default_nettype wire

// [design/spe_entry.sv]
// spe_entry: recognises high- and low-voltage programming entry and holds the session
// assumes pin levels arrive asynchronous to CLK; the programmer clock is sampled, not used as a clock
`timescale 1ns/1ps
`default_nettype none
module spe_entry
   import spe_pkg::*;
#(
   parameter int KEY_BITS = SPE_KEY_BITS,
   parameter logic [31:0] KEY_PATTERN = SPE_KEY_PATTERN
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PROG_SERIAL_CLOCK,
   input wire logic PROG_SERIAL_DATA_IN,
   output logic PROG_SERIAL_DATA_OUT,
   output logic PROG_SERIAL_DATA_OE,
   input wire logic MASTER_CLEAR_PROG_VOLTAGE_LOW,
   input wire logic MASTER_CLEAR_PROG_VOLTAGE_HIGH,
   input wire logic LOW_VOLTAGE_PROG_ENABLE,
   input wire logic MASTER_CLEAR_RESET_CONFIG_EN,
   input wire logic CORE_DATA_OUT,
   input wire logic CORE_DATA_OE,
   input wire logic LOW_VOLTAGE_PROG_ENABLE_CLEAR_REQ,
   output logic PROG_MODE,
   output logic PROG_MODE_LV,
   output logic PROG_MODE_HV,
   output logic PROG_CLOCK_RISE,
   output logic PROG_DATA_SAMPLE,
   output logic MASTER_CLEAR_RESET_EN,
   output logic LOW_VOLTAGE_PROG_ENABLE_CLEAR_ALLOW
);
   // ==========================================================
   // pin synchronisation
   spe_pins_t pins;
   logic [$bits(spe_pins_t)-1:0] pins_raw;
   logic [$bits(spe_pins_t)-1:0] pins_sync;

   assign pins_raw = {PROG_SERIAL_CLOCK, PROG_SERIAL_DATA_IN,
                      MASTER_CLEAR_PROG_VOLTAGE_LOW, MASTER_CLEAR_PROG_VOLTAGE_HIGH};

   spe_sync #(.WIDTH($bits(spe_pins_t))) spe_sync_inst
   (
      .CLK(CLK),
      .RST_B(RST_B),
      .D(pins_raw),
      .Q(pins_sync)
   );

   assign pins = spe_pins_t'(pins_sync);

   // ==========================================================
   // entry state machine and key shifter
   spe_state_t state;
   spe_state_t next_state;
   logic clk_prev;
   logic next_clk_prev;
   logic [31:0] key_shift;
   logic [31:0] next_key_shift;
   logic [5:0] key_cnt;
   logic [5:0] next_key_cnt;
   logic clk_rise;
   logic [5:0] key_last;
   // set by a wrong key, cleared by reset or when master clear leaves its low level
   logic key_lock;
   logic next_key_lock;

   assign clk_rise = pins.clk & ~clk_prev;
   assign key_last = 6'(KEY_BITS - 1);

   always_comb
   begin
      next_state = state;
      next_clk_prev = pins.clk;
      next_key_shift = key_shift;
      next_key_cnt = key_cnt;
      next_key_lock = key_lock & pins.clear_low;
      case (state)
         SPE_IDLE:
         begin
            next_key_cnt = SPE_CNT_ZERO;
            // high voltage wins; clock and data must already be low
            if (pins.hv && !pins.clk && !pins.dat)
               next_state = SPE_HV_SESSION;
            else if (pins.clear_low && LOW_VOLTAGE_PROG_ENABLE && !key_lock)
               next_state = SPE_KEY;
         end
         SPE_KEY:
         begin
            if (!pins.clear_low || !LOW_VOLTAGE_PROG_ENABLE)
               next_state = SPE_IDLE;
            else if (clk_rise)
            begin
               next_key_shift = {key_shift[30:0], pins.dat};
               next_key_cnt = key_cnt + SPE_CNT_ONE;
               if (key_cnt == key_last)
               begin
                  // a wrong key drops back and waits for a fresh master clear cycle
                  if ({key_shift[30:0], pins.dat} == KEY_PATTERN)
                     next_state = SPE_LV_SESSION;
                  else
                  begin
                     next_state = SPE_IDLE;
                     next_key_lock = 1'b1;
                  end
               end
            end
         end
         SPE_LV_SESSION:
         begin
            if (!pins.clear_low)
               next_state = SPE_IDLE;
         end
         SPE_HV_SESSION:
         begin
            if (!pins.hv)
               next_state = SPE_IDLE;
         end
         default:
            next_state = SPE_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state <= SPE_IDLE;
         clk_prev <= 1'b0;
         key_shift <= '0;
         key_cnt <= SPE_CNT_ZERO;
         key_lock <= 1'b0;
      end
      else
      begin
         state <= next_state;
         clk_prev <= next_clk_prev;
         key_shift <= next_key_shift;
         key_cnt <= next_key_cnt;
         key_lock <= next_key_lock;
      end
   end

   // ==========================================================
   // registered outputs
   spe_mode_t next_mode;
   logic next_dout;
   logic next_oe;
   logic next_rise;
   logic next_sample;
   logic next_reset_pin_en;
   logic next_enable_clear_allow;

   always_comb
   begin
      next_mode.lv = (next_state == SPE_LV_SESSION);
      next_mode.hv = (next_state == SPE_HV_SESSION);
      next_mode.active = next_mode.lv | next_mode.hv;
      // data pin is driven only inside a session and only when the core asks
      next_oe = next_mode.active & CORE_DATA_OE;
      next_dout = next_oe & CORE_DATA_OUT;
      // only rises inside an open session reach the core, so the last key bit is never passed on
      next_rise = next_mode.active & PROG_MODE & clk_rise;
      next_sample = pins.dat;
      next_reset_pin_en = LOW_VOLTAGE_PROG_ENABLE | MASTER_CLEAR_RESET_CONFIG_EN;
      next_enable_clear_allow = next_mode.hv & LOW_VOLTAGE_PROG_ENABLE_CLEAR_REQ;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         PROG_MODE <= 1'b0;
         PROG_MODE_LV <= 1'b0;
         PROG_MODE_HV <= 1'b0;
         PROG_SERIAL_DATA_OUT <= 1'b0;
         PROG_SERIAL_DATA_OE <= 1'b0;
         PROG_CLOCK_RISE <= 1'b0;
         PROG_DATA_SAMPLE <= 1'b0;
         // reset pin function stays on until configuration is seen
         MASTER_CLEAR_RESET_EN <= 1'b1;
         LOW_VOLTAGE_PROG_ENABLE_CLEAR_ALLOW <= 1'b0;
      end
      else
      begin
         PROG_MODE <= next_mode.active;
         PROG_MODE_LV <= next_mode.lv;
         PROG_MODE_HV <= next_mode.hv;
         PROG_SERIAL_DATA_OUT <= next_dout;
         PROG_SERIAL_DATA_OE <= next_oe;
         PROG_CLOCK_RISE <= next_rise;
         PROG_DATA_SAMPLE <= next_sample;
         MASTER_CLEAR_RESET_EN <= next_reset_pin_en;
         LOW_VOLTAGE_PROG_ENABLE_CLEAR_ALLOW <= next_enable_clear_allow;
      end
   end
endmodule
`default_nettype wire

// [verif/spe_prog_model.sv]
// spe_prog_model: behavioural programmer on the far side of the pins
// assumes the bench calls its tasks; clock pin stands low between frames
`timescale 1ns/1ps
`default_nettype none
// ==========
// programmer
module spe_prog_model(
   input wire logic DEV_OE,
   input wire logic DEV_OUT,
   output logic PCLK,
   output logic PDAT,
   output logic CLEAR_LO,
   output logic CLEAR_HI
);
   logic drv = 1'b0;
   assign PDAT = DEV_OE ? DEV_OUT : drv;
   initial
   begin
      PCLK = 1'b0;
      CLEAR_LO = 1'b0;
      CLEAR_HI = 1'b0;
   end
   task automatic tick(input logic b);
      drv = b;
      #100 PCLK = 1'b1;
      #100 PCLK = 1'b0;
   endtask
   task automatic hv_enter;
      PCLK = 1'b0;
      drv = 1'b0;
      #100 CLEAR_HI = 1'b1;
   endtask
   // msb first; master clear then held low for the whole session
   task automatic lv_key(input logic [31:0] k);
      CLEAR_LO = 1'b1;
      #100;
      for (int i = 31; i >= 0; i--)
         tick(k[i]);
   endtask
   // released data line shows the inverse, not the stale value
   task automatic quit;
      CLEAR_LO = 1'b0;
      CLEAR_HI = 1'b0;
      drv = ~drv;
   endtask
endmodule
`default_nettype wire

// [verif/spe_entry_chk.sv]
// spe_entry_chk: port assertions for spe_entry
// assumes one CLK domain; bound below by port names
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module spe_entry_chk(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic MASTER_CLEAR_PROG_VOLTAGE_LOW,
   input wire logic MASTER_CLEAR_PROG_VOLTAGE_HIGH,
   input wire logic LOW_VOLTAGE_PROG_ENABLE,
   input wire logic MASTER_CLEAR_RESET_CONFIG_EN,
   input wire logic PROG_SERIAL_DATA_OUT,
   input wire logic PROG_SERIAL_DATA_OE,
   input wire logic PROG_MODE,
   input wire logic PROG_MODE_LV,
   input wire logic PROG_MODE_HV,
   input wire logic PROG_CLOCK_RISE,
   input wire logic MASTER_CLEAR_RESET_EN,
   input wire logic LOW_VOLTAGE_PROG_ENABLE_CLEAR_ALLOW
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   lv_no_clear_a: assert property (PROG_MODE_LV |-> !LOW_VOLTAGE_PROG_ENABLE_CLEAR_ALLOW)
      else $error("clear allowed");
   reset_force_a: assert property (LOW_VOLTAGE_PROG_ENABLE |=> MASTER_CLEAR_RESET_EN)
      else $error("reset off");
   reset_off_a: assert property (!LOW_VOLTAGE_PROG_ENABLE && !MASTER_CLEAR_RESET_CONFIG_EN |=> !MASTER_CLEAR_RESET_EN)
      else $error("reset on");
   data_oe_a: assert property (PROG_SERIAL_DATA_OE |-> PROG_MODE)
      else $error("pin driven outside session");
   data_idle_a: assert property (!PROG_SERIAL_DATA_OE |-> !PROG_SERIAL_DATA_OUT)
      else $error("data set while released");
   rise_session_a: assert property (PROG_CLOCK_RISE |-> PROG_MODE)
      else $error("rise outside session");
   mode_sum_a: assert property (PROG_MODE == (PROG_MODE_LV ^ PROG_MODE_HV)) else $error("mode mix");
   rise_pulse_a: assert property (PROG_CLOCK_RISE |=> !PROG_CLOCK_RISE) else $error("long pulse");
   hv_exit_a: assert property (PROG_MODE_HV && !MASTER_CLEAR_PROG_VOLTAGE_HIGH |-> ##[1:5] !PROG_MODE_HV)
      else $error("hv held");
   lv_exit_a: assert property (PROG_MODE_LV && !MASTER_CLEAR_PROG_VOLTAGE_LOW |-> ##[1:5] !PROG_MODE_LV)
      else $error("lv held");
   lv_needs_en_a: assert property ($rose(PROG_MODE_LV) |-> $past(LOW_VOLTAGE_PROG_ENABLE)) else $error("lv off");
endmodule
bind spe_entry spe_entry_chk spe_entry_chk_inst(.*);
`default_nettype wire

// [verif/spe_entry_bench.sv]
// spe_entry_bench: self-checking bench for spe_entry
// assumes spe_prog_model drives the pins
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module spe_entry_bench;
   import spe_pkg::*;
   logic CLK = 0, RST_B = 0, lve = 0, cfg = 0, cdo = 0, coe = 0, creq = 1;
   wire pclk, pdat, mlo, mhi, dout, doe, mode, mlv, mhv, rise, samp, mrst, allow;
   int mismatches = 0, checks = 0;
   int rises = 0;
   logic last_samp = 1'b0;
   logic [2:0] rows [4] = '{3'b000, 3'b011, 3'b101, 3'b111};
   always #12.5 CLK = ~CLK;
   // counts rise pulses handed to the core and keeps the data sampled with the latest one
   always @(posedge CLK)
      if (rise)
      begin
         rises <= rises + 1;
         last_samp <= samp;
      end
   spe_prog_model spe_prog_model_inst(.DEV_OE(doe), .DEV_OUT(dout), .PCLK(pclk), .PDAT(pdat), .CLEAR_LO(mlo),
      .CLEAR_HI(mhi));
   spe_entry spe_entry_inst(.CLK(CLK), .RST_B(RST_B), .PROG_SERIAL_CLOCK(pclk), .PROG_SERIAL_DATA_IN(pdat),
      .PROG_SERIAL_DATA_OUT(dout), .PROG_SERIAL_DATA_OE(doe), .MASTER_CLEAR_PROG_VOLTAGE_LOW(mlo),
      .MASTER_CLEAR_PROG_VOLTAGE_HIGH(mhi), .LOW_VOLTAGE_PROG_ENABLE(lve), .MASTER_CLEAR_RESET_CONFIG_EN(cfg),
      .CORE_DATA_OUT(cdo), .CORE_DATA_OE(coe), .LOW_VOLTAGE_PROG_ENABLE_CLEAR_REQ(creq), .PROG_MODE(mode),
      .PROG_MODE_LV(mlv), .PROG_MODE_HV(mhv), .PROG_CLOCK_RISE(rise), .PROG_DATA_SAMPLE(samp),
      .MASTER_CLEAR_RESET_EN(mrst), .LOW_VOLTAGE_PROG_ENABLE_CLEAR_ALLOW(allow));
   task automatic chk(input string n, input logic s, input logic e);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #2;
   endtask
   task automatic lv(input logic [31:0] k, input logic en, input logic e);
      int n0;
      n0 = rises;
      lve = en;
      spe_prog_model_inst.lv_key(k);
      cyc(6);
      chk("lv_mode", mlv, e);
      chk("key_no_rise", rises == n0, 1'b1);
      chk("lv_clear", allow, 1'b0);
      spe_prog_model_inst.tick(1'b1);
      chk("lv_rise", rises == (e ? n0 + 1 : n0), 1'b1);
      spe_prog_model_inst.quit();
      cyc(6);
      chk("lv_exit", mlv, 1'b0);
      $display("test lv done");
   endtask
   initial
   begin
      #1000000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      cyc(5);
      chk("rst_pin_en", mrst, 1'b1);
      RST_B = 1;
      foreach (rows[i])
      begin
         {lve, cfg} = rows[i][2:1];
         cyc(2);
         chk("mclr_en", mrst, rows[i][0]);
      end
      $display("test config done");
      spe_prog_model_inst.hv_enter();
      cyc(6);
      chk("hv_mode", mhv, 1'b1);
      chk("hv_clear", allow, 1'b1);
      {coe, cdo} = 2'b11;
      cyc(3);
      chk("data_oe", doe, 1'b1);
      chk("data_out", dout, 1'b1);
      coe = 0;
      cyc(2);
      chk("data_release", doe, 1'b0);
      spe_prog_model_inst.tick(1'b1);
      cyc(4);
      chk("hv_rise", rises == 1, 1'b1);
      chk("hv_sample", last_samp, 1'b1);
      spe_prog_model_inst.tick(1'b0);
      cyc(4);
      chk("hv_rise2", rises == 2, 1'b1);
      chk("hv_sample2", last_samp, 1'b0);
      spe_prog_model_inst.quit();
      cyc(6);
      chk("hv_exit", mode, 1'b0);
      $display("test hv done");
      lv(SPE_KEY_PATTERN, 1'b1, 1'b1);
      lv(~SPE_KEY_PATTERN, 1'b1, 1'b0);
      lv(SPE_KEY_PATTERN, 1'b0, 1'b0);
      // a wrong key locks out a retry until master clear is released
      lve = 1;
      spe_prog_model_inst.lv_key(~SPE_KEY_PATTERN);
      spe_prog_model_inst.lv_key(SPE_KEY_PATTERN);
      cyc(6);
      chk("retry_lock", mlv, 1'b0);
      spe_prog_model_inst.quit();
      cyc(6);
      $display("test retry done");
      // reset in mid-session: session must not survive the release
      spe_prog_model_inst.lv_key(SPE_KEY_PATTERN);
      cyc(6);
      chk("pre_reset", mlv, 1'b1);
      RST_B = 0;
      cyc(1);
      chk("reset_mode", mode, 1'b0);
      chk("reset_pin_en", mrst, 1'b1);
      RST_B = 1;
      cyc(2);
      chk("release_mode", mlv, 1'b0);
      chk("release_pin_en", mrst, 1'b1);
      spe_prog_model_inst.quit();
      cyc(6);
      $display("test reset done");
      complete_run();
   end
endmodule
`default_nettype wire
